// [current_sense_gain_config_regs.v]
`timescale 1ns/10ps
`default_nettype none
`include "sense_gain_map.vh"

// Notes on behaviour
// R1: Overcurrent code maps linearly, 160 plus 15 per step, up to 625.
// R2: AC gain code in bits 3..0; 0 dB, 1.0 dB, then +1.5 dB steps.
// R3: AC register bit 7 reads zero; bits 6..4 stored, never affect gain.
// R4: DC sum enable at bit 7, resets zero; set means DC signal is summed.
// R5: DC gain code in bits 2..0, 19.5 dB up to 35.7 dB ascending.
// R6: DC-gained sense signal always offered to the ADC, enable or not.
// R7: DC register bits 6..4 read zero; bit 3 stored without effect.
module current_sense_gain_config_regs (
  // Clock and reset.
  input wire clk,
  input wire rst_n,
  // Avalon-MM slave.
  input wire [1:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output wire waitrequest,
  output reg [1:0] response,
  // Settings to the analog sense path.
  output reg [9:0] overcurrentThreshold,
  output reg [8:0] acGainTenthDb,
  output reg [8:0] dcGainTenthDb,
  output reg dcGainSumEnable,
  output reg dcSenseToAdc
);

  // Handshake states: a request is latched in idle and answered in the next cycle.
  localparam [0:0] ST_IDLE = 1'b0;
  localparam [0:0] ST_ANSWER = 1'b1;

  // Register file, one byte per word in byte lane 0.
  reg [7:0] overcurrentCtrlReg;
  reg [7:0] senseAcGainCtrl;
  reg [7:0] senseDcGainCtrl;

  // Bus handshake state.
  reg [0:0] busState;
  reg [0:0] next_busState;

  // Read-back path, captured in the stall cycle.
  reg [7:0] next_readByte;
  reg [1:0] next_response;

  // Decoded register fields.
  wire [4:0] overcurrentThresholdCode;
  wire [3:0] acGainCode;
  wire [2:0] dcGainCode;

  // Bus strobes.
  wire request;
  wire requestSeen;
  wire requestDone;
  wire writeDone;
  wire wrOcCtrl;
  wire wrAcGain;
  wire wrDcGain;

  // Next values of the analog settings.
  wire [9:0] next_overcurrentThreshold;
  wire [8:0] next_acGainTenthDb;
  wire [8:0] next_dcGainTenthDb;
  wire next_dcGainSumEnable;

  assign overcurrentThresholdCode = overcurrentCtrlReg[`OC_CODE_MSB:`OC_CODE_LSB];
  assign acGainCode = senseAcGainCtrl[`AC_CODE_MSB:`AC_CODE_LSB];
  assign dcGainCode = senseDcGainCtrl[`DC_CODE_MSB:`DC_CODE_LSB];

  assign request = read || write;
  assign requestSeen = request && (busState == ST_IDLE);
  assign requestDone = request && (busState == ST_ANSWER);
  // Writes take effect only on the completing edge, where waitrequest is low.
  // A write with lane 0 switched off completes normally but stores nothing.
  assign writeDone = requestDone && write && byteenable[0];
  assign wrOcCtrl = writeDone && isAddr(address, `ADDR_OC_CTRL);
  assign wrAcGain = writeDone && isAddr(address, `ADDR_AC_GAIN);
  assign wrDcGain = writeDone && isAddr(address, `ADDR_DC_GAIN);

  // One wait cycle: every request stalls in its first cycle so that the read-back
  // byte can be registered before the master takes it.
  assign waitrequest = requestSeen;

  // Decoding is continuous; the results pass through flip-flops further down.
  assign next_overcurrentThreshold = ocDecode(overcurrentThresholdCode); // R1
  assign next_acGainTenthDb = acDecode(acGainCode); // R2
  assign next_dcGainTenthDb = dcDecode(dcGainCode); // R5
  assign next_dcGainSumEnable = senseDcGainCtrl[`DC_EN_BIT]; // R4

  function [9:0] ocDecode;
    input [4:0] code;
    begin
      ocDecode = `OC_BASE + (`OC_STEP * {5'h00, code});
    end
  endfunction

  function [8:0] acDecode;
    input [3:0] code;
    begin
      if (code == 4'h0) begin
        acDecode = 9'h000;
      end else begin
        acDecode = `AC_FIRST_STEP + (`AC_STEP * {5'h00, code - 4'h1});
      end
    end
  endfunction

  function [8:0] dcDecode;
    input [2:0] code;
    begin
      case (code)
        3'h0: dcDecode = `DC_G0;
        3'h1: dcDecode = `DC_G1;
        3'h2: dcDecode = `DC_G2;
        3'h3: dcDecode = `DC_G3;
        3'h4: dcDecode = `DC_G4;
        3'h5: dcDecode = `DC_G5;
        3'h6: dcDecode = `DC_G6;
        default: dcDecode = `DC_G7;
      endcase
    end
  endfunction

  // Address compare shared by the write strobes.
  function isAddr;
    input [1:0] addr;
    input [1:0] target;
    begin
      isAddr = (addr == target);
    end
  endfunction

  // Lane-0 write through a mask; bits outside the mask are never stored and read as zero.
  function [7:0] maskedByte;
    input [7:0] data;
    input [7:0] mask;
    begin
      maskedByte = data & mask;
    end
  endfunction

  // Next handshake state. The answer cycle always returns to idle, so a request
  // still held afterwards counts as a new one and stalls again.
  always @* begin
    next_busState = busState;
    case (busState)
      ST_IDLE: begin
        if (request) begin
          next_busState = ST_ANSWER;
        end
      end
      ST_ANSWER: begin
        next_busState = ST_IDLE;
      end
      default: begin
        next_busState = ST_IDLE;
      end
    endcase
  end

  // Handshake state register.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busState <= ST_IDLE;
    end else begin
      busState <= next_busState;
    end
  end

  // Read-back byte for the addressed word; unimplemented bits read zero.
  always @* begin
    next_readByte = 8'h00;
    case (address)
      `ADDR_OC_CTRL: begin
        next_readByte = overcurrentCtrlReg;
      end
      `ADDR_AC_GAIN: begin
        next_readByte = senseAcGainCtrl; // R3
      end
      `ADDR_DC_GAIN: begin
        next_readByte = senseDcGainCtrl; // R7
      end
      `ADDR_STATUS: begin
        next_readByte = {5'h00, dcGainCode};
      end
      default: begin
        next_readByte = 8'h00;
      end
    endcase
  end

  // The status word is read-only, so a write to it is refused with an error response.
  always @* begin
    next_response = `RESP_OKAY;
    case (address)
      `ADDR_STATUS: begin
        if (write) begin
          next_response = `RESP_SLVERR;
        end
      end
      default: begin
        next_response = `RESP_OKAY;
      end
    endcase
  end

  // Read data is captured in the stall cycle so that it stands at the completing edge.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
    end else if (requestSeen) begin
      readdata <= {24'h00_0000, next_readByte};
    end
  end

  // The response is captured together with the read data.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      response <= `RESP_OKAY;
    end else if (requestSeen) begin
      response <= next_response;
    end
  end

  // Overcurrent control keeps all eight bits; only the threshold code is decoded here.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overcurrentCtrlReg <= `OC_RESET;
    end else if (wrOcCtrl) begin
      overcurrentCtrlReg <= maskedByte(writedata[7:0], `OC_WRITE_MASK);
    end
  end

  // Bit 7 is not implemented; the reserved bits are kept but never reach the decoder.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      senseAcGainCtrl <= `AC_RESET;
    end else if (wrAcGain) begin
      senseAcGainCtrl <= maskedByte(writedata[7:0], `AC_WRITE_MASK); // R3
    end
  end

  // Bits 6 to 4 are not implemented; the reserved bit 3 is kept for read-back only.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      senseDcGainCtrl <= `DC_RESET;
    end else if (wrDcGain) begin
      senseDcGainCtrl <= maskedByte(writedata[7:0], `DC_WRITE_MASK); // R7
    end
  end

  // Decoded settings are registered so the analog trims never see decoder glitches.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overcurrentThreshold <= 10'h000;
    end else begin
      overcurrentThreshold <= next_overcurrentThreshold; // R1
    end
  end

  // AC gain setting in tenths of a dB.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acGainTenthDb <= 9'h000;
    end else begin
      acGainTenthDb <= next_acGainTenthDb; // R2
    end
  end

  // DC gain setting in tenths of a dB; applied whether or not it is summed.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dcGainTenthDb <= 9'h000;
    end else begin
      dcGainTenthDb <= next_dcGainTenthDb; // R5
    end
  end

  // Summing of the DC-gained signal into the AC path.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dcGainSumEnable <= 1'b0;
    end else begin
      dcGainSumEnable <= next_dcGainSumEnable; // R4
    end
  end

  // The DC-gained signal is always offered to the converter, summed or not.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dcSenseToAdc <= 1'b0;
    end else begin
      dcSenseToAdc <= 1'b1; // R6
    end
  end

endmodule
`default_nettype wire

// [sense_gain_map.vh]
`ifndef SENSE_GAIN_MAP_VH
`define SENSE_GAIN_MAP_VH

// Register word addresses (Avalon word index), one per register word.
`define ADDR_OC_CTRL 2'h0
`define ADDR_AC_GAIN 2'h1
`define ADDR_DC_GAIN 2'h2
`define ADDR_STATUS 2'h3

// Avalon response codes.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Overcurrent control register fields.
`define OC_CODE_MSB 4
`define OC_CODE_LSB 0
`define OC_WRITE_MASK 8'hff
`define OC_RESET 8'h00
`define OC_BASE 10'h0a0
`define OC_STEP 10'h00f

// AC gain register fields.
`define AC_CODE_MSB 3
`define AC_CODE_LSB 0
`define AC_WRITE_MASK 8'h7f
`define AC_RESET 8'h00

// DC gain register fields.
`define DC_EN_BIT 7
`define DC_RSVD_BIT 3
`define DC_CODE_MSB 2
`define DC_CODE_LSB 0
`define DC_WRITE_MASK 8'h8f
`define DC_RESET 8'h00

// Gain values in tenths of a dB.
`define AC_FIRST_STEP 9'h00a
`define AC_STEP 9'h00f
`define DC_G0 9'h0c3
`define DC_G1 9'h0da
`define DC_G2 9'h0f1
`define DC_G3 9'h107
`define DC_G4 9'h11e
`define DC_G5 9'h135
`define DC_G6 9'h14c
`define DC_G7 9'h165

`endif

// [sense_gain_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module sense_gain_monitor (
  input wire logic clk, rst_n, read, write, waitrequest, dcGainSumEnable, dcSenseToAdc,
  input wire logic [1:0] address,
  input wire logic [31:0] writedata, readdata,
  input wire logic [3:0] byteenable,
  input wire logic [9:0] overcurrentThreshold,
  input wire logic [8:0] acGainTenthDb, dcGainTenthDb
);
  localparam logic [71:0] DCT = {9'h165, 9'h14c, 9'h135, 9'h11e, 9'h107, 9'h0f1, 9'h0da, 9'h0c3};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire wr = write && !waitrequest && byteenable[0];
  wire rd = read && !waitrequest;
  a_oc_decode: assert property (wr && address == 2'h0 |-> ##2
    overcurrentThreshold == 10'h0a0 + 10'h00f * $past(writedata[4:0], 2)) else $error("bad oc");
  a_ac_decode: assert property (wr && address == 2'h1 |-> ##2 acGainTenthDb ==
    ($past(writedata[3:0], 2) == 4'h0 ? 9'h000 : 9'h00a + 9'h00f * ($past(writedata[3:0], 2)
    - 4'h1))) else $error("bad ac gain");
  a_ac_top_zero: assert property (rd && address == 2'h1 |-> !readdata[7]) else $error("ac b7");
  a_sum_enable: assert property (wr && address == 2'h2 |-> ##2
    dcGainSumEnable == $past(writedata[7], 2)) else $error("bad sum enable");
  a_dc_decode: assert property (wr && address == 2'h2 |-> ##2
    dcGainTenthDb == DCT[$past(writedata[2:0], 2) * 9 +: 9]) else $error("bad dc gain");
  a_adc_route: assert property ($past(rst_n) |-> dcSenseToAdc) else $error("adc off");
  a_dc_gap_zero: assert property (rd && address == 2'h2 |-> readdata[6:4] == 3'h0)
    else $error("dc gap");
endmodule
`default_nettype wire

// [tb_current_sense_gain_config_regs.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_current_sense_gain_config_regs;
  logic clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0;
  logic waitrequest, dcGainSumEnable, dcSenseToAdc;
  logic [1:0] address = 2'h0, response, qr;
  logic [31:0] writedata = 32'h0, readdata, seed = 32'h150a2, r, q;
  logic [3:0] byteenable = 4'h0;
  logic [9:0] overcurrentThreshold;
  logic [8:0] acGainTenthDb, dcGainTenthDb;
  logic [7:0] oc, ac, dc;
  int error_cnt = 0, comparisons = 0;
  localparam logic [71:0] DCT = {9'h165, 9'h14c, 9'h135, 9'h11e, 9'h107, 9'h0f1, 9'h0da, 9'h0c3};
  current_sense_gain_config_regs current_sense_gain_config_regs_i (.clk, .rst_n, .address,
    .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .response,
    .overcurrentThreshold, .acGainTenthDb, .dcGainTenthDb, .dcGainSumEnable, .dcSenseToAdc);
  initial forever #10 clk = ~clk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] acExp(input logic [3:0] c);
    return c == 4'h0 ? 32'h0 : 32'ha + 32'hf * (c - 4'h1);
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // The request is held until an edge at which waitrequest is low; one idle edge follows.
  task automatic xfer(input logic [1:0] a, input logic w, input logic [7:0] d,
    input logic [3:0] be);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= {r[31:8], d};
    byteenable <= be;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata;
    qr = response;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic tally_and_finish();
    $display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    r = 32'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    cmp(overcurrentThreshold, 32'ha0);
    cmp(acGainTenthDb, 32'h0);
    cmp(dcGainTenthDb, DCT[8:0]);
    cmp(dcGainSumEnable, 32'h0);
    cmp(dcSenseToAdc, 32'h1);
    @(posedge clk);
    for (int i = 0; i < 32; i++) begin
      r = xs();
      oc = {r[7:5], i[4:0]};
      ac = {r[15:12], i[3:0]};
      dc = {r[23:19], i[2:0]};
      xfer(2'h0, 1'b1, oc, {r[26:24], 1'b1});
      xfer(2'h1, 1'b1, ac, 4'hf);
      xfer(2'h2, 1'b1, dc, 4'h1);
      // Lane 0 disabled, so this write must leave the dc register alone.
      xfer(2'h2, 1'b1, ~dc, 4'he);
      xfer(2'h3, 1'b1, ~dc, 4'hf);
      cmp(qr, 32'h2);
      xfer(2'h3, 1'b0, 8'h00, 4'hf);
      cmp(q, {29'h0, dc[2:0]});
      cmp(qr, 32'h0);
      xfer(2'h1, 1'b0, 8'h00, 4'hf);
      cmp(q, {25'h0, ac[6:0]});
      xfer(2'h2, 1'b0, 8'h00, 4'hf);
      cmp(q, {24'h0, dc[7], 3'h0, dc[3:0]});
      @(negedge clk);
      cmp(overcurrentThreshold, 32'ha0 + 32'hf * i[4:0]);
      cmp(acGainTenthDb, acExp(i[3:0]));
      cmp(dcGainSumEnable, dc[7]);
      cmp(dcGainTenthDb, DCT[i[2:0] * 9 +: 9]);
      cmp(dcSenseToAdc, 32'h1);
      @(posedge clk);
    end
    // A second reset in mid-run must bring back the power-on DC sum enable, DC gain setting and DC register.
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    cmp(dcGainSumEnable, 32'h0);
    cmp(dcGainTenthDb, DCT[8:0]);
    @(posedge clk);
    xfer(2'h2, 1'b0, 8'h00, 4'hf);
    cmp(q, 32'h0);
    tally_and_finish();
  end
endmodule
bind current_sense_gain_config_regs sense_gain_monitor sense_gain_monitor_i (.clk, .rst_n,
  .read, .write, .waitrequest, .dcGainSumEnable, .dcSenseToAdc, .address, .writedata,
  .readdata, .byteenable, .overcurrentThreshold, .acGainTenthDb, .dcGainTenthDb);
`default_nettype wire
